//--- core/nvpin_top.sv
// pin function logic for two multi pins and the auxiliary port
`default_nettype none
module nvpin_top import nvpin_pkg::*; #(
  parameter int unsigned PULSE_CYC = PULSE_WIDTH_CYC,
  parameter int unsigned START_CYC = STARTUP_CYC,
  parameter int unsigned SEC_CYC   = PERIOD_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire nvpin_fn_t  sel_pin_one,
  input  wire nvpin_fn_t  sel_pin_two,
  input  wire nvpin_fn_t  sel_aux,
  input  wire nvpin_fix_t fix_type,
  input  wire logic       time_corr,
  input  wire logic       multi_pin_one_i,
  input  wire logic       multi_pin_two_i,
  input  wire logic       aux_rx_i,
  output var  logic       multi_pin_one_o,
  output var  logic       multi_pin_one_oe_n,
  output var  logic       multi_pin_two_o,
  output var  logic       multi_pin_two_oe_n,
  output var  logic       aux_tx_o,
  output var  logic       aux_tx_oe_n,
  output var  logic       second_pulse_output,
  output var  logic       time_valid,
  output var  logic       stationary,
  output var  logic       mag_disable,
  output var  logic       rcvr_disable,
  output var  logic       pres_disable,
  output var  logic       zero_align_pulse,
  output var  logic       align_zeroed
);
  localparam logic [CNT_W-1:0] PW_C     = CNT_W'(PULSE_CYC);
  localparam logic [CNT_W-1:0] START_M1 = CNT_W'(START_CYC - 1);
  localparam logic [CNT_W-1:0] SEC_M1   = CNT_W'(SEC_CYC - 1);
  localparam logic [CNT_W-1:0] AUX_ON   = CNT_W'(SEC_CYC - PULSE_CYC);

  nvpin_fn_t             sel [NUM_PINS];
  logic [NUM_PINS-1:0]   pin_in;
  logic [NUM_PINS-1:0]   in_s;
  logic [NUM_PINS-1:0]   prev_q;
  logic [NUM_PINS-1:0]   out_q;
  logic [NUM_PINS-1:0]   oe_n_q;
  logic [NUM_PINS-1:0]   stat_hit;
  logic [NUM_PINS-1:0]   mag_hit;
  logic [NUM_PINS-1:0]   rcvr_hit;
  logic [NUM_PINS-1:0]   pres_hit;
  logic [NUM_PINS-1:0]   rise;
  logic [CNT_W-1:0]      start_cnt_q;
  logic [CNT_W-1:0]      sec_cnt_q;
  logic                  run_q;
  logic                  pps_lvl;
  logic                  aux_lvl;
  logic                  fix_hi;
  logic                  time_valid_q;
  logic                  stationary_q;
  logic                  mag_disable_q;
  logic                  rcvr_disable_q;
  logic                  pres_disable_q;
  logic                  zero_pulse_q;
  logic                  align_zeroed_q;

  assign sel[PIN_ONE] = sel_pin_one;
  assign sel[PIN_TWO] = sel_pin_two;
  assign sel[PIN_AUX] = sel_aux;
  assign pin_in       = {aux_rx_i, multi_pin_two_i, multi_pin_one_i};

  nvpin_sync #(
    .WIDTH (NUM_PINS)
  ) u_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in (pin_in),
    .sync_out (in_s)
  );

  // startup delay, no other condition gates it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      start_cnt_q <= '0;
    end else if (!run_q) begin
      start_cnt_q <= start_cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      run_q <= 1'h0;
    end else if (!run_q && start_cnt_q == START_M1) begin
      run_q <= 1'h1;
    end
  end

  // a correction restarts the second at once, so one interval is short
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !run_q) begin
      sec_cnt_q <= '0;
    end else if (time_corr || sec_cnt_q == SEC_M1) begin
      sec_cnt_q <= '0;
    end else begin
      sec_cnt_q <= sec_cnt_q + CNT_W'(1);
    end
  end

  // pins rise at the boundary; aux is high just before and falls on it
  assign pps_lvl = run_q && (sec_cnt_q < PW_C);
  assign aux_lvl = run_q && (sec_cnt_q >= AUX_ON);

  // set only by a correction; nothing here can judge time loss
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      time_valid_q <= 1'h0;
    end else if (time_corr) begin
      time_valid_q <= 1'h1;
    end
  end

  always_comb begin
    unique case (fix_type)
      NVPIN_FIX_3D, NVPIN_FIX_SBAS, NVPIN_FIX_DIFF, NVPIN_FIX_RTK: fix_hi = 1'h1;
      NVPIN_FIX_NONE, NVPIN_FIX_2D:                               fix_hi = 1'h0;
      default:                                                    fix_hi = 1'h0;
    endcase
  end

  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pin
      // selection is read every cycle, so it can change at any time
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          out_q[p]  <= OUT_RESET;
          oe_n_q[p] <= OE_N_RESET;
        end else begin
          unique case (sel[p])
            NVPIN_FN_PULSE_OUT: begin
              out_q[p]  <= (p == PIN_AUX) ? aux_lvl : pps_lvl;
              oe_n_q[p] <= 1'h0;
            end
            NVPIN_FN_FIX_OUT: begin
              out_q[p]  <= fix_hi;
              oe_n_q[p] <= 1'h0;
            end
            NVPIN_FN_INACTIVE, NVPIN_FN_STATIONARY, NVPIN_FN_MAG_DIS,
            NVPIN_FN_RCVR_DIS, NVPIN_FN_PRES_DIS, NVPIN_FN_ZERO_ALIGN: begin
              out_q[p]  <= 1'h0;
              oe_n_q[p] <= 1'h1;
            end
          endcase
        end
      end

      // edge history runs always, so selecting the mode with the pin high is no edge
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          prev_q[p] <= 1'h0;
        end else begin
          prev_q[p] <= in_s[p];
        end
      end

      assign stat_hit[p] = (sel[p] == NVPIN_FN_STATIONARY) && in_s[p];
      assign mag_hit[p]  = (sel[p] == NVPIN_FN_MAG_DIS) && in_s[p];
      assign rcvr_hit[p] = (sel[p] == NVPIN_FN_RCVR_DIS) && in_s[p];
      assign pres_hit[p] = (sel[p] == NVPIN_FN_PRES_DIS) && in_s[p];
      // a bouncing switch would give one zeroing per bounce
      assign rise[p] = (sel[p] == NVPIN_FN_ZERO_ALIGN) && in_s[p] && !prev_q[p];
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stationary_q   <= 1'h0;
      mag_disable_q  <= 1'h0;
      rcvr_disable_q <= 1'h0;
      pres_disable_q <= 1'h0;
    end else begin
      stationary_q   <= |stat_hit;
      mag_disable_q  <= |mag_hit;
      rcvr_disable_q <= |rcvr_hit;
      pres_disable_q <= |pres_hit;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      zero_pulse_q <= 1'h0;
    end else begin
      zero_pulse_q <= |rise;
    end
  end

  // volatile only; persisting it is the host's job via the alignment packet
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      align_zeroed_q <= 1'h0;
    end else if (|rise) begin
      align_zeroed_q <= 1'h1;
    end
  end

  assign multi_pin_one_o     = out_q[PIN_ONE];
  assign multi_pin_one_oe_n  = oe_n_q[PIN_ONE];
  assign multi_pin_two_o     = out_q[PIN_TWO];
  assign multi_pin_two_oe_n  = oe_n_q[PIN_TWO];
  assign aux_tx_o            = out_q[PIN_AUX];
  assign aux_tx_oe_n         = oe_n_q[PIN_AUX];
  assign second_pulse_output = pps_lvl;
  assign time_valid          = time_valid_q;
  assign stationary          = stationary_q;
  assign mag_disable         = mag_disable_q;
  assign rcvr_disable        = rcvr_disable_q;
  assign pres_disable        = pres_disable_q;
  assign zero_align_pulse    = zero_pulse_q;
  assign align_zeroed        = align_zeroed_q;

  property p_pulse_width;
    @(posedge clk_sys) disable iff (sys_rst)
      $fell(pps_lvl) |-> (sec_cnt_q == PW_C);
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse fell at wrong count");

  property p_startup;
    @(posedge clk_sys) disable iff (sys_rst)
      $rose(run_q) |-> ($past(start_cnt_q) == START_M1) && pps_lvl;
  endproperty
  a_startup: assert property (p_startup) else $error("pulses started at wrong time");

  property p_every_second;
    @(posedge clk_sys) disable iff (sys_rst)
      (run_q && sec_cnt_q == SEC_M1 && !pps_lvl) |=> $rose(pps_lvl);
  endproperty
  a_every_second: assert property (p_every_second) else $error("missed second pulse");

  property p_realign;
    @(posedge clk_sys) disable iff (sys_rst)
      (run_q && time_corr) |=> (sec_cnt_q == '0) && pps_lvl;
  endproperty
  a_realign: assert property (p_realign) else $error("correction did not realign");

  property p_aux_falls;
    @(posedge clk_sys) disable iff (sys_rst)
      (run_q && sec_cnt_q == SEC_M1 && PULSE_CYC > 0) |-> aux_lvl ##1 (!aux_lvl && pps_lvl);
  endproperty
  a_aux_falls: assert property (p_aux_falls) else $error("aux edge not on boundary");

  property p_time_valid;
    @(posedge clk_sys) disable iff (sys_rst)
      time_corr |=> time_valid ##1 time_valid;
  endproperty
  a_time_valid: assert property (p_time_valid) else $error("time valid not held");

  property p_fix_out;
    @(posedge clk_sys) disable iff (sys_rst)
      (sel_pin_one == NVPIN_FN_FIX_OUT) |=> !multi_pin_one_oe_n
        && (multi_pin_one_o == ($past(fix_type) inside {NVPIN_FIX_3D, NVPIN_FIX_SBAS, NVPIN_FIX_DIFF, NVPIN_FIX_RTK}));
  endproperty
  a_fix_out: assert property (p_fix_out) else $error("fix output wrong");

  property p_stationary;
    @(posedge clk_sys) disable iff (sys_rst)
      (sel_pin_two == NVPIN_FN_STATIONARY && in_s[PIN_TWO]) |=> stationary;
  endproperty
  a_stationary: assert property (p_stationary) else $error("stationary not reported");

  property p_disables;
    @(posedge clk_sys) disable iff (sys_rst)
      (sel_aux == NVPIN_FN_MAG_DIS && sel_pin_one == NVPIN_FN_RCVR_DIS && sel_pin_two == NVPIN_FN_PRES_DIS)
        |=> (mag_disable == $past(in_s[PIN_AUX])) && (rcvr_disable == $past(in_s[PIN_ONE]))
            && (pres_disable == $past(in_s[PIN_TWO]));
  endproperty
  a_disables: assert property (p_disables) else $error("disable level wrong");

  property p_zero_edge;
    @(posedge clk_sys) disable iff (sys_rst)
      (sel_pin_one == NVPIN_FN_ZERO_ALIGN && in_s[PIN_ONE] && !prev_q[PIN_ONE])
        |=> zero_align_pulse && align_zeroed ##1 !zero_align_pulse || $rose(zero_align_pulse);
  endproperty
  a_zero_edge: assert property (p_zero_edge) else $error("zero alignment edge missed");

  property p_volatile;
    @(posedge clk_sys) sys_rst |=> !align_zeroed;
  endproperty
  a_volatile: assert property (p_volatile) else $error("alignment survived reset");

  property p_tristate;
    @(posedge clk_sys) disable iff (sys_rst)
      (sel_aux != NVPIN_FN_PULSE_OUT && sel_aux != NVPIN_FN_FIX_OUT) |=> aux_tx_oe_n && !aux_tx_o;
  endproperty
  a_tristate: assert property (p_tristate) else $error("input mode drives pin");

  c_realign_short: cover property (@(posedge clk_sys) disable iff (sys_rst) run_q && time_corr && !pps_lvl);
  c_aux_pulse:     cover property (@(posedge clk_sys) disable iff (sys_rst) $fell(aux_tx_o));
  c_zero_align:    cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(align_zeroed));
  c_sel_change:    cover property (@(posedge clk_sys) disable iff (sys_rst) $changed(sel_pin_one) && run_q);
endmodule // nvpin_top
`default_nettype wire

//--- core/nvpin_pkg.sv
// shared constants and types for the navigation unit pin function block
`default_nettype none
package nvpin_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned PULSE_WIDTH_MS  = 50;
  localparam int unsigned STARTUP_MS      = 100;
  localparam int unsigned PULSE_PERIOD_MS = 1000;
  localparam int unsigned PULSE_WIDTH_CYC = PULSE_WIDTH_MS * CYC_PER_MS;
  localparam int unsigned STARTUP_CYC     = STARTUP_MS * CYC_PER_MS;
  localparam int unsigned PERIOD_CYC      = PULSE_PERIOD_MS * CYC_PER_MS;
  localparam int unsigned CNT_W           = 24;
  localparam int unsigned NUM_PINS        = 3;
  localparam int unsigned PIN_ONE         = 0;
  localparam int unsigned PIN_TWO         = 1;
  localparam int unsigned PIN_AUX         = 2;
  localparam logic        OUT_RESET       = 1'h0;
  localparam logic        OE_N_RESET      = 1'h1;

  typedef enum logic [2:0] {
    NVPIN_FN_INACTIVE,
    NVPIN_FN_PULSE_OUT,
    NVPIN_FN_FIX_OUT,
    NVPIN_FN_STATIONARY,
    NVPIN_FN_MAG_DIS,
    NVPIN_FN_RCVR_DIS,
    NVPIN_FN_PRES_DIS,
    NVPIN_FN_ZERO_ALIGN
  } nvpin_fn_t;

  typedef enum logic [2:0] {
    NVPIN_FIX_NONE,
    NVPIN_FIX_2D,
    NVPIN_FIX_3D,
    NVPIN_FIX_SBAS,
    NVPIN_FIX_DIFF,
    NVPIN_FIX_RTK
  } nvpin_fix_t;
endpackage
`default_nettype wire

//--- core/nvpin_sync.sv
// three-stage input synchroniser with agreement filter
`default_nettype none
module nvpin_sync import nvpin_pkg::*; #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] stable_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept a level only once two later stages agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          stable_q[g] <= 1'h0;
        end else if (s2_q[g] == s3_q[g]) begin
          stable_q[g] <= s3_q[g];
        end
      end
    end
  endgenerate

  assign sync_out = stable_q;
endmodule // nvpin_sync
`default_nettype wire

//--- sim/nvpin_far.sv
// far-side model: switches wired to the two multi pins and the aux port, receivers to the multi pins only
`default_nettype none
module nvpin_far (
  input  wire logic clk_sys,
  input  wire logic want_one,
  input  wire logic want_two,
  input  wire logic want_aux,
  input  wire logic one_o,
  input  wire logic one_oe_n,
  input  wire logic two_o,
  input  wire logic two_oe_n,
  output var  logic one_i,
  output var  logic two_i,
  output var  logic aux_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] drv_q;
  // switch levels move only just after an edge, one clean step each
  // no host here: a zeroed alignment lasts only until reset unless resent
  always_ff @(posedge clk_sys) begin
    drv_q <= {want_aux, want_two, want_one};
  end
  // shared wire: the device wins while its enable is low
  always_comb begin
    one_i = one_oe_n ? drv_q[0] : one_o;
    two_i = two_oe_n ? drv_q[1] : two_o;
    aux_i = drv_q[2];
  end
endmodule // nvpin_far
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the pin function block
`default_nettype none
module tb import nvpin_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // shortened counts keep the run brief
  localparam int unsigned P_W = 5;
  localparam int unsigned P_S = 10;
  localparam int unsigned P_T = 40;
  logic       clk_sys = 1'h0;
  logic       sys_rst = 1'h1;
  nvpin_fn_t  sel_one = NVPIN_FN_INACTIVE;
  nvpin_fn_t  sel_two = NVPIN_FN_INACTIVE;
  nvpin_fn_t  sel_aux = NVPIN_FN_INACTIVE;
  nvpin_fix_t fix     = NVPIN_FIX_NONE;
  logic       tcorr   = 1'h0;
  logic       w_one   = 1'h0;
  logic       w_two   = 1'h0;
  logic       w_aux   = 1'h0;
  logic       one_i, two_i, aux_i;
  logic       one_o, one_oe_n, two_o, two_oe_n, ax_o, ax_oe_n;
  logic       spo, tv, st, md, rd, pd, zp, az;
  int         miscompares = 0;
  int         n_tests = 0;
  int         k;

  always #50 clk_sys = ~clk_sys;

  nvpin_top #(.PULSE_CYC(P_W), .START_CYC(P_S), .SEC_CYC(P_T)) i_nvpin_top (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sel_pin_one(sel_one), .sel_pin_two(sel_two),
    .sel_aux(sel_aux), .fix_type(fix), .time_corr(tcorr), .multi_pin_one_i(one_i),
    .multi_pin_two_i(two_i), .aux_rx_i(aux_i), .multi_pin_one_o(one_o), .multi_pin_one_oe_n(one_oe_n),
    .multi_pin_two_o(two_o), .multi_pin_two_oe_n(two_oe_n), .aux_tx_o(ax_o), .aux_tx_oe_n(ax_oe_n),
    .second_pulse_output(spo), .time_valid(tv), .stationary(st), .mag_disable(md),
    .rcvr_disable(rd), .pres_disable(pd), .zero_align_pulse(zp), .align_zeroed(az));

  nvpin_far i_nvpin_far (
    .clk_sys(clk_sys), .want_one(w_one), .want_two(w_two), .want_aux(w_aux),
    .one_o(one_o), .one_oe_n(one_oe_n), .two_o(two_o), .two_oe_n(two_oe_n),
    .one_i(one_i), .two_i(two_i), .aux_i(aux_i));

  task automatic close_out();
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // sample just after the edge so its updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_spo(input logic lvl, output int n);
    n = 0;
    while (spo !== lvl) begin
      step(1);
      n++;
      if (n > 200) begin
        miscompares++;
        $display("ERROR at %0t: timing pulse wait ran out", $time);
        close_out();
      end
    end
  endtask

  initial begin
    step(7);
    chk({one_o, two_o, ax_o, one_oe_n, two_oe_n, ax_oe_n, spo, az}, 8'h1C);
    @(posedge clk_sys);
    sys_rst <= 1'h0;
    sel_one <= NVPIN_FN_PULSE_OUT;
    sel_aux <= NVPIN_FN_PULSE_OUT;
    #1;
    wait_spo(1'h1, k);
    chk(8'(k >= P_S - 2 && k <= P_S + 1), 8'h01);
    chk(8'(tv), 8'h00);
    wait_spo(1'h0, k);
    chk(8'(k), 8'(P_W));
    wait_spo(1'h1, k);
    chk(8'(k + P_W), 8'(P_T));
    chk({one_o, ax_o}, 8'h01);
    step(1);
    chk({one_o, ax_o, one_oe_n, ax_oe_n}, 8'h08);
    // correction in mid-second restarts the pulse early
    wait_spo(1'h0, k);
    step(10);
    @(posedge clk_sys);
    tcorr <= 1'h1;
    @(posedge clk_sys);
    tcorr <= 1'h0;
    #1;
    chk({spo, tv}, 8'h03);
    wait_spo(1'h0, k);
    chk(8'(k), 8'(P_W));
    @(posedge clk_sys);
    sel_one <= NVPIN_FN_FIX_OUT;
    sel_two <= NVPIN_FN_FIX_OUT;
    for (int f = 0; f < 8; f++) begin
      @(posedge clk_sys);
      fix <= nvpin_fix_t'(3'(f));
      step(1);
      chk({one_o, two_o, one_oe_n, two_oe_n}, {4'h0, {2{1'(f >= 2 && f <= 5)}}, 2'h0});
    end
    // each level input on a rotating pin, others tristated
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys);
      sel_one <= ((m + 1) % 3 == 0) ? nvpin_fn_t'(3'(3 + m)) : NVPIN_FN_INACTIVE;
      sel_two <= ((m + 1) % 3 == 1) ? nvpin_fn_t'(3'(3 + m)) : NVPIN_FN_INACTIVE;
      sel_aux <= ((m + 1) % 3 == 2) ? nvpin_fn_t'(3'(3 + m)) : NVPIN_FN_INACTIVE;
      w_one <= ((m + 1) % 3 == 0);
      w_two <= ((m + 1) % 3 == 1);
      w_aux <= ((m + 1) % 3 == 2);
      step(2);
      chk({st, md, rd, pd}, 8'h00);
      step(8);
      chk({st, md, rd, pd}, 8'h08 >> m);
      chk({one_oe_n, two_oe_n, ax_oe_n, one_o, two_o}, 8'h1C);
      @(posedge clk_sys);
      w_one <= 1'h0;
      w_two <= 1'h0;
      w_aux <= 1'h0;
      step(10);
      chk({st, md, rd, pd}, 8'h00);
    end
    // three disables selected at once, one per pin, with only mag and pres driven high
    @(posedge clk_sys);
    sel_aux <= NVPIN_FN_MAG_DIS;
    sel_one <= NVPIN_FN_RCVR_DIS;
    sel_two <= NVPIN_FN_PRES_DIS;
    w_aux <= 1'h1;
    w_two <= 1'h1;
    step(10);
    chk({st, md, rd, pd}, 8'h05);
    @(posedge clk_sys);
    sel_one <= NVPIN_FN_ZERO_ALIGN;
    step(4);
    @(posedge clk_sys);
    w_one <= 1'h1;
    k = 0;
    repeat (12) begin
      step(1);
      if (zp === 1'h1) k++;
    end
    chk(8'(k), 8'h01);
    chk(8'(az), 8'h01);
    // alignment must not survive a reset
    @(posedge clk_sys);
    sys_rst <= 1'h1;
    w_one <= 1'h0;
    step(4);
    @(posedge clk_sys);
    sys_rst <= 1'h0;
    step(1);
    chk(8'(az), 8'h00);
    step(8);
    chk({az, zp}, 8'h00);
    close_out();
  end
endmodule // tb
`default_nettype wire
